/* File: rtl/urd_pkg.sv */
// constants and types shared by the serial receive data recovery block
package urd_pkg;
    // sample tick positions inside one bit time (a count of 0 stands for the sixteenth)
    localparam logic [3:0] RT_EDGE = 4'h1;
    localparam logic [3:0] RT_START_A = 4'h3;
    localparam logic [3:0] RT_START_B = 4'h5;
    localparam logic [3:0] RT_START_C = 4'h7;
    localparam logic [3:0] RT_MID_A = 4'h8;
    localparam logic [3:0] RT_MID_B = 4'h9;
    localparam logic [3:0] RT_MID_C = 4'ha;
    localparam logic [3:0] RT_BIT_END = 4'h0;
    localparam logic [3:0] RT_RESET = 4'h0;
    // character lengths in data bits
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    // idle-line search history of three high samples
    localparam logic [2:0] HIST_ALL_HIGH = 3'h7;
    localparam logic [2:0] HIST_RESET = 3'h0;
    // buffer depth and reset values
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [10:0] ENTRY_RESET = 11'h000;
    localparam logic [8:0] SHIFT_RESET = 9'h000;
    localparam logic [3:0] COUNT_RESET = 4'h0;

    typedef enum logic [1:0] {
        URD_IDLE = 2'b00,
        URD_START = 2'b01,
        URD_DATA = 2'b10,
        URD_STOP = 2'b11
    } urd_state_t;
endpackage : urd_pkg

/* File: rtl/urd_receiver.sv */
// receive data recovery: start search, majority sampling, flags and two-entry buffer
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - characters are eight or nine bits; nine-bit mode stores bit eight separately
// - in eight-bit mode the ninth-bit field copies data bit seven
// - bits shift into a receive shift register; data buffer is read only
// - a completed character moves to the data buffer and sets receiver full
// - receiver interrupt request while full flag and its enable are both set
// - line is sampled on a tick running sixteen times the baud rate
// - tick phase realigns on the start edge and on a one-to-zero data change
// - start search wants a low sample after three highs, then counts sixteen
// - start checked at ticks three, five, seven; one high is noise, two reject
// - a rejected start resets the tick counter and restarts the search
// - data bit is majority of ticks eight to ten; disagreement sets noise
// - middle start samples skip verification but any high among them is noise
// - stop bit majority of ticks eight to ten; low majority is framing error
// - no high level in stop position, as in a break, gives framing error
// - framing error appears in the same cycle as receiver full
// - a valid falling edge realigns the tick counter only in data bits, at ticks two to seven or eleven to sixteen
// - stop sampled at tick ten after nine or ten sixteen-tick bit times
// - character arriving with no buffer room is dropped and overrun is set
// - break sets framing, full and break flags with zero data and ninth bit
module urd_receiver (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // serial line and sample tick from the baud generator
    input wire logic rxd_in,
    input wire logic sample_tick_in,
    // control
    input wire logic module_enable_in,
    input wire logic rx_enable_in,
    input wire logic char_nine_bit_in,
    input wire logic rx_full_irq_enable_in,
    input wire logic buffer_read_in,
    input wire logic overrun_clear_in,
    // received character and status
    output logic [7:0] serial_data_buffer_out,
    output logic rx_ninth_bit_out,
    output logic rx_full_flag_out,
    output logic framing_error_flag_out,
    output logic noise_flag_out,
    output logic break_flag_out,
    output logic overrun_flag_out,
    output logic rx_irq_out,
    output logic rx_busy_out
);

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction : maj3

    ////////////////////////////////////////////////////////////////////////////////
    // line synchroniser and search history

    logic rxd_meta, rxd_sync, rxd_last;
    logic [2:0] hist;

    // the pin is asynchronous: two flops before anything looks at it
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
        end
        else
        begin
            rxd_meta <= rxd_in;
            rxd_sync <= rxd_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bit timing and sample decoding

    urd_pkg::urd_state_t state;
    urd_pkg::urd_state_t next_state;
    logic [3:0] rt;
    logic [3:0] next_rt;
    logic [3:0] bit_idx;
    logic [3:0] next_bit_idx;
    logic [2:0] next_hist;
    logic [3:0] rt_now;
    logic s_a, s_b, last_major, nf_acc, enabled, tick;
    logic [8:0] shreg;
    logic [3:0] nbits;
    logic [1:0] start_ones;
    logic start_seen, start_check, start_bad, mid_done, major, disagree;
    logic rt_early, rt_late, fall_edge, resync, bit_end, last_bit;
    logic push, stop_fe, stop_nf, is_break;

    assign enabled = module_enable_in & rx_enable_in;
    assign tick = sample_tick_in & enabled;
    assign nbits = char_nine_bit_in ? urd_pkg::BITS_NINE : urd_pkg::BITS_EIGHT;
    // a low sample after three highs is a possible start edge
    assign start_seen = (state == urd_pkg::URD_IDLE) & tick & ~rxd_sync
        & (hist == urd_pkg::HIST_ALL_HIGH);
    assign start_ones = {1'b0, s_a} + {1'b0, s_b} + {1'b0, rxd_sync};
    assign rt_now = rt + 4'h1; // rt holds the tick just taken, rt_now the one being taken
    assign start_check = (state == urd_pkg::URD_START) & tick & (rt_now == urd_pkg::RT_START_C);
    assign start_bad = start_check & start_ones[1];
    // majority and disagreement over ticks eight, nine and ten
    assign mid_done = tick & (rt_now == urd_pkg::RT_MID_C);
    assign major = maj3(s_a, s_b, rxd_sync);
    assign disagree = ~((s_a == s_b) & (s_b == rxd_sync));
    // a falling edge after a one bit realigns the tick; late in a bit it also ends it
    assign rt_early = (rt_now >= 4'h2) & (rt_now <= urd_pkg::RT_START_C);
    assign rt_late = (rt_now > urd_pkg::RT_MID_C) | (rt_now == urd_pkg::RT_BIT_END);
    assign fall_edge = (state == urd_pkg::URD_DATA) & tick & last_major & rxd_last & ~rxd_sync;
    assign resync = fall_edge & (rt_early | rt_late);
    assign bit_end = tick & ((rt_now == urd_pkg::RT_BIT_END) | (resync & rt_late));
    assign last_bit = (bit_idx == nbits - 4'h1);
    // stop bit verdict at tick ten of the stop bit
    assign push = (state == urd_pkg::URD_STOP) & mid_done;
    assign stop_fe = ~major;
    assign stop_nf = disagree;
    assign is_break = stop_fe & (shreg == urd_pkg::SHIFT_RESET);

    // next state, tick phase and bit index
    always_comb
    begin
        next_state = state;
        next_rt = (tick & (state != urd_pkg::URD_IDLE)) ? rt + 4'h1 : rt;
        next_bit_idx = bit_idx;
        next_hist = tick ? {hist[1:0], rxd_sync} : hist;
        unique case (state)
            urd_pkg::URD_IDLE:
            begin
                next_rt = urd_pkg::RT_RESET;
                if (start_seen)
                begin
                    next_state = urd_pkg::URD_START;
                    next_rt = urd_pkg::RT_EDGE;
                end
            end
            urd_pkg::URD_START:
            begin
                if (start_bad)
                begin
                    next_state = urd_pkg::URD_IDLE;
                    next_rt = urd_pkg::RT_RESET;
                    next_hist = urd_pkg::HIST_RESET;
                end
                else if (tick & (rt_now == urd_pkg::RT_BIT_END))
                begin
                    next_state = urd_pkg::URD_DATA;
                    next_bit_idx = urd_pkg::COUNT_RESET;
                end
            end
            urd_pkg::URD_DATA:
            begin
                if (resync)
                    next_rt = urd_pkg::RT_EDGE;
                if (bit_end)
                begin
                    next_bit_idx = bit_idx + 4'h1;
                    if (last_bit)
                        next_state = urd_pkg::URD_STOP;
                end
            end
            urd_pkg::URD_STOP:
            begin
                if (push)
                begin
                    next_state = urd_pkg::URD_IDLE;
                    next_hist = urd_pkg::HIST_RESET;
                end
            end
        endcase
        if (!enabled)
        begin
            next_state = urd_pkg::URD_IDLE;
            next_hist = urd_pkg::HIST_RESET;
        end
    end

    // sequencer registers; idle search restarts from a cleared history so noise cannot fake a start
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state <= urd_pkg::URD_IDLE;
            rt <= urd_pkg::RT_RESET;
            bit_idx <= urd_pkg::COUNT_RESET;
            hist <= urd_pkg::HIST_RESET;
            rxd_last <= 1'b1;
        end
        else
        begin
            state <= next_state;
            rt <= next_rt;
            bit_idx <= next_bit_idx;
            hist <= next_hist;
            rxd_last <= tick ? rxd_sync : rxd_last;
        end
    end

    // sample capture: ticks three/five or eight/nine feed the vote with the live sample
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s_a <= 1'b0;
            s_b <= 1'b0;
        end
        else
        begin
            if (tick & ((rt_now == urd_pkg::RT_START_A) | (rt_now == urd_pkg::RT_MID_A)))
                s_a <= rxd_sync;
            if (tick & ((rt_now == urd_pkg::RT_START_B) | (rt_now == urd_pkg::RT_MID_B)))
                s_b <= rxd_sync;
        end
    end

    // shift register, last majority and noise accumulated over the character
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            shreg <= urd_pkg::SHIFT_RESET;
            last_major <= 1'b0;
            nf_acc <= 1'b0;
        end
        else if (start_seen)
        begin
            shreg <= urd_pkg::SHIFT_RESET;
            last_major <= 1'b0;
            nf_acc <= 1'b0;
        end
        else
        begin
            if ((state == urd_pkg::URD_DATA) & mid_done)
            begin
                shreg <= {major, shreg[8:1]};
                last_major <= major;
            end
            if (start_check & (start_ones == 2'h1))
                nf_acc <= 1'b1;
            if ((state == urd_pkg::URD_START) & mid_done & (major | disagree))
                nf_acc <= 1'b1;
            if ((state == urd_pkg::URD_DATA) & mid_done & disagree)
                nf_acc <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // two-entry receive buffer: entry0 is what the cpu sees

    logic [1:0] cnt, next_cnt;
    logic [10:0] entry0, entry1, new_entry, next_entry0, next_entry1, next_head;
    logic [7:0] new_data;
    logic new_ninth, do_pop, buf_ready, push_ok, overrun_set, next_full;

    // eight-bit data sits in the upper shifted bits; ninth bit is bit 8 or a copy of bit 7
    assign new_data = is_break ? 8'h00 : (char_nine_bit_in ? shreg[7:0] : shreg[8:1]);
    assign new_ninth = is_break ? 1'b0 : shreg[8];
    assign new_entry = {new_ninth, new_data, stop_fe, nf_acc | stop_nf};
    assign do_pop = buffer_read_in & (cnt != urd_pkg::BUF_EMPTY);
    assign buf_ready = (cnt != urd_pkg::BUF_DEPTH) | do_pop;
    assign push_ok = push & buf_ready;
    assign overrun_set = push & ~buf_ready;
    assign next_cnt = cnt + {1'b0, push_ok} - {1'b0, do_pop};
    assign next_full = (next_cnt != urd_pkg::BUF_EMPTY);
    assign next_entry0 = do_pop ? ((cnt == urd_pkg::BUF_DEPTH) ? entry1 : new_entry)
        : ((cnt == urd_pkg::BUF_EMPTY) ? new_entry : entry0);
    assign next_entry1 = (push_ok & (next_cnt == urd_pkg::BUF_DEPTH)) ? new_entry : entry1;
    assign next_head = (push_ok | do_pop) ? next_entry0 : entry0;

    // buffer storage; a new character never replaces an unread one
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt <= urd_pkg::BUF_EMPTY;
            entry0 <= urd_pkg::ENTRY_RESET;
            entry1 <= urd_pkg::ENTRY_RESET;
        end
        else
        begin
            cnt <= next_cnt;
            if (push_ok | do_pop)
                entry0 <= next_entry0;
            entry1 <= next_entry1;
        end
    end

    // head data and ninth bit come straight from the head entry's flops
    assign serial_data_buffer_out = entry0[9:2];
    assign rx_ninth_bit_out = entry0[10];

    // status flops; overrun set wins over a clear in the same cycle
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_full_flag_out <= 1'b0;
            framing_error_flag_out <= 1'b0;
            noise_flag_out <= 1'b0;
            break_flag_out <= 1'b0;
            rx_irq_out <= 1'b0;
            overrun_flag_out <= 1'b0;
            rx_busy_out <= 1'b0;
        end
        else
        begin
            rx_full_flag_out <= next_full;
            // head flags are masked by the next full value so they stay plain flops
            framing_error_flag_out <= next_head[1] & next_full;
            noise_flag_out <= next_head[0] & next_full;
            break_flag_out <= next_head[1] & next_full & (next_head[10:2] == 9'h000);
            rx_irq_out <= next_full & rx_full_irq_enable_in;
            overrun_flag_out <= overrun_set | (overrun_flag_out & ~overrun_clear_in);
            rx_busy_out <= (next_state != urd_pkg::URD_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_start_entry: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        start_seen |=> (state == urd_pkg::URD_START) && (rt == urd_pkg::RT_EDGE))
        else $error("start edge did not begin the tick count");
    a_start_reject: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        start_bad |=> (state == urd_pkg::URD_IDLE) && (rt == urd_pkg::RT_RESET))
        else $error("bad start bit was not rejected");
    a_data_shift_in: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        ((state == urd_pkg::URD_DATA) && mid_done && !start_seen) |=> shreg[8] == $past(major))
        else $error("data majority not shifted in");
    a_frame_with_full: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (push_ok && cnt == urd_pkg::BUF_EMPTY && stop_fe)
        |=> rx_full_flag_out && framing_error_flag_out)
        else $error("framing error not raised with receiver full");
    a_ninth_copy: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (push_ok && cnt == urd_pkg::BUF_EMPTY && !char_nine_bit_in)
        |=> rx_ninth_bit_out == serial_data_buffer_out[7])
        else $error("ninth bit does not copy bit seven");
    a_overrun_keeps: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        overrun_set |=> overrun_flag_out && $stable(serial_data_buffer_out))
        else $error("overrun lost old data or flag");
    a_break_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        break_flag_out |-> framing_error_flag_out && !rx_ninth_bit_out)
        else $error("break character left data or flags wrong");
    a_irq_level: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        ##1 rx_irq_out == (rx_full_flag_out && $past(rx_full_irq_enable_in)))
        else $error("interrupt request does not follow full and enable");
    a_disable_abort: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !enabled |=> (state == urd_pkg::URD_IDLE) && !$rose(rx_full_flag_out))
        else $error("disabled receiver kept a character going");
    a_stop_bounded: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state == urd_pkg::URD_STOP) && tick && (rt_now == urd_pkg::RT_MID_C)
        |=> state == urd_pkg::URD_IDLE)
        else $error("stop sample did not end the character");

    c_good_char: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        push_ok && !stop_fe && !nf_acc);
    c_break_char: cover property (@(posedge clk_in) disable iff (!rst_b_in) push && is_break);
    c_resync: cover property (@(posedge clk_in) disable iff (!rst_b_in) resync);
    c_overrun: cover property (@(posedge clk_in) disable iff (!rst_b_in) overrun_set);

endmodule : urd_receiver

`default_nettype wire

/* File: verif/urd_tx_model.sv */
// partner model: remote serial transmitter paced by the sample tick
`timescale 1ns/1ps
`default_nettype none
module urd_tx_model (
    // clock and pacing
    input wire logic clk_in,
    input wire logic sample_tick_in,
    // serial line toward the receiver
    output logic rxd_out
);
    ////////////////////////////////////////////////////////////////////////
    // the line idles high; a low idle would look like an endless start bit
    initial rxd_out = 1'b1;

    // wait for a tick edge, so the line changes just after the receiver's sample
    task automatic wait_tick();
        @(posedge clk_in);
        while (sample_tick_in !== 1'b1)
            @(posedge clk_in);
    endtask : wait_tick

    // send bits lsb first, bit_ticks ticks per bit (16 nominal, 15 fast, 17 slow),
    // one sample inverted only where the bench asks, then sixteen idle ticks
    task automatic send(input logic [10:0] bits, input int count, input int bit_ticks,
                        input int bad_bit, input int bad_tick);
        for (int i = 0; i < count; i++)
        begin
            for (int t = 1; t <= bit_ticks; t++)
            begin
                wait_tick();
                rxd_out <= (i == bad_bit && t == bad_tick) ? ~bits[i] : bits[i];
            end
        end
        for (int t = 0; t < 16; t++)
        begin
            wait_tick();
            rxd_out <= 1'b1;
        end
    endtask : send
endmodule : urd_tx_model
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the serial receive data recovery block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // design inputs, outputs and bench state
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic rxd;
    logic sample_tick_in = 1'b0;
    logic module_enable_in = 1'b1;
    logic rx_enable_in = 1'b1;
    logic char_nine_bit_in = 1'b0;
    logic rx_full_irq_enable_in = 1'b1;
    logic buffer_read_in = 1'b0;
    logic overrun_clear_in = 1'b0;
    logic [7:0] data;
    logic ninth, full, fe, nf, bk, ovr, irq, busy;
    logic [1:0] tick_div = 2'h0;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int glitch_bit [4] = '{0, 0, 1, 9};
    int glitch_tick [4] = '{3, 8, 9, 9};

    ////////////////////////////////////////////////////////////////////////
    urd_receiver u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .rxd_in(rxd),
        .sample_tick_in(sample_tick_in), .module_enable_in(module_enable_in),
        .rx_enable_in(rx_enable_in), .char_nine_bit_in(char_nine_bit_in),
        .rx_full_irq_enable_in(rx_full_irq_enable_in), .buffer_read_in(buffer_read_in),
        .overrun_clear_in(overrun_clear_in), .serial_data_buffer_out(data),
        .rx_ninth_bit_out(ninth), .rx_full_flag_out(full), .framing_error_flag_out(fe),
        .noise_flag_out(nf), .break_flag_out(bk), .overrun_flag_out(ovr),
        .rx_irq_out(irq), .rx_busy_out(busy));
    urd_tx_model u_tx (.clk_in(clk_in), .sample_tick_in(sample_tick_in), .rxd_out(rxd));

    // clock, and a sample tick every fourth cycle to keep frames short
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        tick_div <= tick_div + 2'h1;
        sample_tick_in <= (tick_div == 2'h3);
    end

    // hang guard: about sixteen frames of some 750 cycles fit well inside
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : chk_byte

    task automatic chk_bit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            $display("BAD %s expected %b seen %b", name, exp, got);
            fail_count++;
        end
    endtask : chk_bit

    // head character with its flags; full must be set whenever a head is shown
    task automatic chk_head(input logic [7:0] d, input logic n8, input logic f,
                            input logic n, input logic b);
        chk_bit("full", 1'b1, full);
        chk_byte("data", d, data);
        chk_bit("ninth", n8, ninth);
        chk_bit("framing", f, fe);
        chk_bit("noise", n, nf);
        chk_bit("break", b, bk);
    endtask : chk_head

    // one character from the far side in the current length mode
    task automatic rx(input logic [8:0] d, input logic stop, input int bt, input int bb,
                      input int btk);
        if (char_nine_bit_in)
            u_tx.send({stop, d, 1'b0}, 11, bt, bb, btk);
        else
            u_tx.send({1'b1, stop, d[7:0], 1'b0}, 10, bt, bb, btk);
        #1;
    endtask : rx

    // one-cycle pop; the next head shows one cycle after the pop edge
    task automatic pop();
        @(posedge clk_in);
        buffer_read_in <= 1'b1;
        @(posedge clk_in);
        buffer_read_in <= 1'b0;
        @(posedge clk_in);
        #1;
    endtask : pop

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        // the start search wants three high ticks before a low one counts
        repeat (20) @(posedge clk_in);
        rx(9'h0a5, 1'b1, 16, -1, 0);
        chk_head(8'ha5, 1'b1, 1'b0, 1'b0, 1'b0);
        chk_bit("irq", 1'b1, irq);
        chk_bit("busy", 1'b0, busy);
        @(posedge clk_in);
        rx_full_irq_enable_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk_bit("irq", 1'b0, irq);
        pop();
        chk_bit("full", 1'b0, full);
        // nine-bit character keeps bit eight apart from bit seven
        @(posedge clk_in);
        char_nine_bit_in <= 1'b1;
        rx(9'h13c, 1'b1, 16, -1, 0);
        chk_head(8'h3c, 1'b1, 1'b0, 1'b0, 1'b0);
        pop();
        @(posedge clk_in);
        char_nine_bit_in <= 1'b0;
        // low stop bit, then a break with all bits low
        rx(9'h081, 1'b0, 16, -1, 0);
        chk_head(8'h81, 1'b1, 1'b1, 1'b0, 1'b0);
        pop();
        rx(9'h000, 1'b0, 16, -1, 0);
        chk_head(8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
        pop();
        // one bad sample in start, start middle, data and stop positions
        for (int i = 0; i < 4; i++)
        begin
            rx(9'h05a, 1'b1, 16, glitch_bit[i], glitch_tick[i]);
            chk_head(8'h5a, 1'b0, 1'b0, 1'b1, 1'b0);
            pop();
        end
        // short low pulse is rejected, and the search resumes for a real start
        u_tx.send(11'h7fe, 1, 4, -1, 0);
        #1;
        chk_bit("full", 1'b0, full);
        rx(9'h0c3, 1'b1, 16, -1, 0);
        chk_head(8'hc3, 1'b1, 1'b0, 1'b0, 1'b0);
        pop();
        // fast and slow far side; only resync on falling edges keeps the stop in reach
        for (int bt = 15; bt <= 17; bt += 2)
        begin
            rx(9'h055, 1'b1, bt, -1, 0);
            chk_head(8'h55, 1'b0, 1'b0, 1'b0, 1'b0);
            pop();
        end
        // third character with both entries held is dropped
        rx(9'h011, 1'b1, 16, -1, 0);
        rx(9'h022, 1'b1, 16, -1, 0);
        chk_bit("overrun", 1'b0, ovr);
        rx(9'h033, 1'b1, 16, -1, 0);
        chk_bit("overrun", 1'b1, ovr);
        chk_byte("data", 8'h11, data);
        pop();
        chk_byte("data", 8'h22, data);
        pop();
        pop();
        chk_bit("full", 1'b0, full);
        @(posedge clk_in);
        overrun_clear_in <= 1'b1;
        @(posedge clk_in);
        overrun_clear_in <= 1'b0;
        @(posedge clk_in);
        #1;
        chk_bit("overrun", 1'b0, ovr);
        // module, then receiver, switched off in mid-character drops it
        for (int k = 0; k < 2; k++)
        begin
            fork
                rx(9'h0ff, 1'b1, 16, -1, 0);
                begin
                    repeat (200) @(posedge clk_in);
                    #1;
                    chk_bit("busy", 1'b1, busy);
                    @(posedge clk_in);
                    if (k == 0)
                        module_enable_in <= 1'b0;
                    else
                        rx_enable_in <= 1'b0;
                    repeat (10) @(posedge clk_in);
                    module_enable_in <= 1'b1;
                    rx_enable_in <= 1'b1;
                end
            join
            chk_bit("full", 1'b0, full);
            chk_bit("busy", 1'b0, busy);
        end
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
